// *** logic/rslc_defs.svh ***
// Purpose: constants for the reset, strap and led control block
// Assumes: mclk at 20 MHz, 32-bit register bus, byte addresses
// Notes: definitions only
`ifndef RSLC_DEFS_SVH
`define RSLC_DEFS_SVH

`define RSLC_ADDR_W 8
`define RSLC_OFF_WAN_MISC 8'h00
`define RSLC_OFF_SW_CTRL0 8'h04
`define RSLC_OFF_WDT_CTRL 8'h08
`define RSLC_OFF_WDT_LOAD 8'h0C
`define RSLC_OFF_STATUS 8'h10

`define RSLC_WAN_A_LSB 0
`define RSLC_WAN_B_LSB 4
`define RSLC_LAN_A_LSB 25
`define RSLC_LAN_B_LSB 22
`define RSLC_WDT_EN_BIT 0
`define RSLC_WDT_KICK_BIT 1

`define RSLC_WAN_MISC_RST 32'h0000_0010
`define RSLC_SW_CTRL0_RST 32'h0240_0000
`define RSLC_WDT_LOAD_RST 32'h00FF_FFFF

`define RSLC_LED_OFF 3'h7
`define RSLC_BOOT_RSVD 2'h0
`define RSLC_RESP_OKAY 2'h0
`define RSLC_RESP_SLVERR 2'h2

// time base: reset pin minimum given in internal system clocks, counted in mclk cycles
`define RSLC_MCLK_KHZ 20000
`define RSLC_SYSCLK_KHZ 125000
`define RSLC_RST_MIN_SYSCLK 256
`define RSLC_RST_MIN_CYC ((`RSLC_RST_MIN_SYSCLK * `RSLC_MCLK_KHZ + `RSLC_SYSCLK_KHZ - 1) / `RSLC_SYSCLK_KHZ)
`define RSLC_HOLD_MS 200
`define RSLC_HOLD_CYC (`RSLC_HOLD_MS * `RSLC_MCLK_KHZ)

`endif

// *** logic/rslc_pkg.sv ***
// Purpose: types for the reset, strap and led control block
// Assumes: used through rslc_pkg::name
// Notes: numbers live in rslc_defs.svh
package rslc_pkg;
  typedef enum logic [1:0] {
    ST_RESET,
    ST_RUN,
    ST_WDT
  } rslc_state_t;
endpackage : rslc_pkg

// *** logic/rslc_top.sv ***
// Purpose: chip reset qualify, reset output, strap capture, led select
// Assumes: one clock mclk; pins pass two flops; axi4-lite slave
// Notes: led status inputs come from logic on mclk, bit 0 wan, 1..4 lan
`include "rslc_defs.svh"

////////////////////////////////////////////////////////////////////////
// Overview of operation
// - while in reset every led pin is released, enables low
// - reset output asserted at least 200ms on chip reset or watchdog expiry
// - polarity strap sampled in reset: 0 active high, 1 active low
// - clock source strap: 0 pll clocks the cpu, 1 test clock input
// - two wan led straps give boot width: 01 byte, 10 half, 11 word
// - each led shows status picked by its 3-bit select code
// - first wan led follows wan misc control bits 2..0
// - second wan led follows wan misc control bits 6..4
// - first led of each lan port follows switch control 0 bits 27..25
// - second led of each lan port follows switch control 0 bits 24..22
// - 25MHz reference feeds the pll making the 125MHz system clock
// - watchdog expiry resets the device and asserts the reset output
module rslc_top #(
  parameter int HOLD_CYC = `RSLC_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chip_reset_n,
  input wire logic pll_locked,
  input wire logic reset_out_polarity_strap,
  input wire logic cpu_clock_source_strap,
  input wire logic wan_led_a_pin,
  input wire logic wan_led_b_pin,
  input wire logic [4:0] speed_st,
  input wire logic [4:0] link_st,
  input wire logic [4:0] duplex_st,
  input wire logic [4:0] col_st,
  input wire logic [4:0] act_st,
  output logic sys_reset_out,
  output logic core_reset_out,
  output logic cpu_clk_from_test,
  output logic [1:0] boot_bank_width,
  output logic wan_led_a_drv,
  output logic wan_led_a_oe,
  output logic wan_led_b_drv,
  output logic wan_led_b_oe,
  output logic [3:0] lan_led_a,
  output logic [3:0] lan_led_b,
  output logic lan_led_oe,
  input wire logic [`RSLC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`RSLC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int RST_MIN = `RSLC_RST_MIN_CYC;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  logic [5:0] pin_m_r;
  logic [5:0] pin_s_r;
  wire [5:0] pin_raw = {wan_led_b_pin, wan_led_a_pin, cpu_clock_source_strap,
                        reset_out_polarity_strap, pll_locked, chip_reset_n};
  always_ff @(posedge mclk) begin
    pin_m_r <= pin_raw;
    pin_s_r <= pin_m_r;
  end
  wire rstn_s = pin_s_r[0];
  wire lock_s = pin_s_r[1];

  ////////////////////////////////////////////////////////////////////
  // reset qualification; a shorter low pulse is ignored as a glitch
  logic [8:0] low_cnt_r;
  logic chip_rst_r;
  wire low_full = (low_cnt_r >= 9'(RST_MIN));
  always_ff @(posedge mclk) begin
    if (sys_rst || rstn_s) begin
      low_cnt_r <= 9'h000;
    end else if (!low_full) begin
      low_cnt_r <= low_cnt_r + 9'h001;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chip_rst_r <= 1'b1;
    end else if (low_full) begin
      chip_rst_r <= 1'b1;
    end else if (rstn_s) begin
      chip_rst_r <= 1'b0;
    end
  end
  // no running clock until the pll has locked on the reference
  wire hold_in_rst = chip_rst_r || !lock_s;

  ////////////////////////////////////////////////////////////////////
  // watchdog
  logic [31:0] wdt_load_r;
  logic [31:0] wdt_cnt_r;
  logic wdt_en_r;
  logic wdt_kick;
  wire wdt_expire = wdt_en_r && (wdt_cnt_r == 32'h0000_0000);

  ////////////////////////////////////////////////////////////////////
  // sequencer
  rslc_pkg::rslc_state_t st_r;
  rslc_pkg::rslc_state_t st_nxt;
  logic [21:0] hold_cnt_r;
  wire hold_done = (hold_cnt_r >= 22'(HOLD_CYC));
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rslc_pkg::ST_RESET: if (!hold_in_rst) st_nxt = rslc_pkg::ST_RUN;
      rslc_pkg::ST_RUN: begin
        if (hold_in_rst) st_nxt = rslc_pkg::ST_RESET;
        else if (wdt_expire) st_nxt = rslc_pkg::ST_WDT;
      end
      rslc_pkg::ST_WDT: begin
        if (hold_in_rst) st_nxt = rslc_pkg::ST_RESET;
        else if (hold_done) st_nxt = rslc_pkg::ST_RUN;
      end
      default: st_nxt = rslc_pkg::ST_RESET;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) st_r <= rslc_pkg::ST_RESET;
    else st_r <= st_nxt;
  end
  wire in_rst = (st_r == rslc_pkg::ST_RESET);
  wire run = (st_r == rslc_pkg::ST_RUN);
  wire soft_clr = !run;

  // hold count restarts on every reset cause, so the output lasts at least 200ms
  always_ff @(posedge mclk) begin
    if (sys_rst || in_rst || wdt_expire) begin
      hold_cnt_r <= 22'h000000;
    end else if (!hold_done) begin
      hold_cnt_r <= hold_cnt_r + 22'h000001;
    end
  end
  wire out_active = in_rst || !hold_done || wdt_expire;

  ////////////////////////////////////////////////////////////////////
  // strap capture at release
  logic pol_r;
  logic clk_test_r;
  logic [1:0] bw_r;
  wire capture = in_rst && (st_nxt == rslc_pkg::ST_RUN);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pol_r <= 1'b1;
      clk_test_r <= 1'b0;
      bw_r <= `RSLC_BOOT_RSVD;
    end else if (capture) begin
      pol_r <= pin_s_r[2];
      clk_test_r <= pin_s_r[3];
      bw_r <= {pin_s_r[5], pin_s_r[4]};
    end
  end
  // before capture the live strap decides the level, no default exists
  wire pol_now = in_rst ? pin_s_r[2] : pol_r;
  wire rst_lvl = out_active ? !pol_now : pol_now;

  ////////////////////////////////////////////////////////////////////
  // register bus
  logic [31:0] wan_misc_r;
  logic [31:0] sw_ctrl0_r;
  logic [7:0] aw_q_r;
  logic wr_go_r;
  logic wdt_flag_r;
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire sel_wan = (aw_q_r == `RSLC_OFF_WAN_MISC);
  wire sel_sw = (aw_q_r == `RSLC_OFF_SW_CTRL0);
  wire sel_wc = (aw_q_r == `RSLC_OFF_WDT_CTRL);
  wire sel_wl = (aw_q_r == `RSLC_OFF_WDT_LOAD);
  wire wr_hit = sel_wan || sel_sw || sel_wc || sel_wl || (aw_q_r == `RSLC_OFF_STATUS);
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic [31:0] wmask;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[g*8 +: 8] = {8{ws_r[g]}};
    end
  endgenerate
  wire [31:0] wan_w = (wan_misc_r & ~wmask) | (wd_r & wmask);
  wire [31:0] sw_w = (sw_ctrl0_r & ~wmask) | (wd_r & wmask);
  wire [31:0] wl_w = (wdt_load_r & ~wmask) | (wd_r & wmask);
  assign wdt_kick = wr_go_r && sel_wc && ws_r[0] && wd_r[`RSLC_WDT_KICK_BIT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_go_r <= 1'b0;
      aw_q_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
    end else begin
      s_axi_awready <= wr_take;
      s_axi_wready <= wr_take;
      wr_go_r <= s_axi_awready;
      if (wr_take) begin
        aw_q_r <= s_axi_awaddr;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSLC_RESP_OKAY;
    end else if (wr_go_r) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RSLC_RESP_OKAY : `RSLC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // any reset cause returns the controls to defaults
  always_ff @(posedge mclk) begin
    if (sys_rst || soft_clr) begin
      wan_misc_r <= `RSLC_WAN_MISC_RST;
      sw_ctrl0_r <= `RSLC_SW_CTRL0_RST;
      wdt_load_r <= `RSLC_WDT_LOAD_RST;
      wdt_en_r <= 1'b0;
    end else if (wr_go_r) begin
      if (sel_wan) wan_misc_r <= wan_w;
      if (sel_sw) sw_ctrl0_r <= sw_w;
      if (sel_wl) wdt_load_r <= wl_w;
      if (sel_wc && ws_r[0]) wdt_en_r <= wd_r[`RSLC_WDT_EN_BIT];
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || soft_clr || wdt_kick || !wdt_en_r) begin
      wdt_cnt_r <= wdt_load_r;
    end else if (!wdt_expire) begin
      wdt_cnt_r <= wdt_cnt_r - 32'h0000_0001;
    end
  end
  // only a pin reset or sys_rst clears the cause flag; an expiry wins over a pin reset in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) wdt_flag_r <= 1'b0;
    else if (wdt_expire) wdt_flag_r <= 1'b1;
    else if (chip_rst_r) wdt_flag_r <= 1'b0;
  end

  wire rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire [31:0] status_w = {26'h0000000, wdt_flag_r, out_active, pol_r, clk_test_r, bw_r};
  wire [31:0] wdt_ctrl_w = {31'h00000000, wdt_en_r};
  wire rd_wan = (s_axi_araddr == `RSLC_OFF_WAN_MISC);
  wire rd_sw = (s_axi_araddr == `RSLC_OFF_SW_CTRL0);
  wire rd_wc = (s_axi_araddr == `RSLC_OFF_WDT_CTRL);
  wire rd_wl = (s_axi_araddr == `RSLC_OFF_WDT_LOAD);
  wire rd_st = (s_axi_araddr == `RSLC_OFF_STATUS);
  wire rd_hit = rd_wan || rd_sw || rd_wc || rd_wl || rd_st;
  wire [31:0] rd_mux = rd_wan ? wan_misc_r : rd_sw ? sw_ctrl0_r : rd_wc ? wdt_ctrl_w :
                       rd_wl ? wdt_load_r : rd_st ? status_w : 32'h0000_0000;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RSLC_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `RSLC_RESP_OKAY : `RSLC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // led select: code 7 unused, shows off
  logic [7:0] opt [5];
  logic [4:0] led_a;
  logic [4:0] led_b;
  wire [2:0] wan_sel_a = wan_misc_r[`RSLC_WAN_A_LSB +: 3];
  wire [2:0] wan_sel_b = wan_misc_r[`RSLC_WAN_B_LSB +: 3];
  wire [2:0] lan_sel_a = sw_ctrl0_r[`RSLC_LAN_A_LSB +: 3];
  wire [2:0] lan_sel_b = sw_ctrl0_r[`RSLC_LAN_B_LSB +: 3];
  generate
    for (g = 0; g < 5; g++) begin : g_port
      // link/activity: lit on link, dark while traffic
      assign opt[g] = {1'b0, link_st[g] & ~act_st[g], duplex_st[g] & col_st[g],
                       act_st[g], col_st[g], duplex_st[g], link_st[g], speed_st[g]};
      assign led_a[g] = (g == 0) ? opt[g][wan_sel_a] : opt[g][lan_sel_a];
      assign led_b[g] = (g == 0) ? opt[g][wan_sel_b] : opt[g][lan_sel_b];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // output flops; enables dropped during reset so straps can be read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sys_reset_out <= 1'b0;
      core_reset_out <= 1'b1;
      cpu_clk_from_test <= 1'b0;
      boot_bank_width <= `RSLC_BOOT_RSVD;
      wan_led_a_drv <= 1'b0;
      wan_led_b_drv <= 1'b0;
      lan_led_a <= 4'h0;
      lan_led_b <= 4'h0;
      wan_led_a_oe <= 1'b0;
      wan_led_b_oe <= 1'b0;
      lan_led_oe <= 1'b0;
    end else begin
      sys_reset_out <= rst_lvl;
      core_reset_out <= !run;
      cpu_clk_from_test <= clk_test_r;
      boot_bank_width <= bw_r;
      wan_led_a_drv <= led_a[0];
      wan_led_b_drv <= led_b[0];
      lan_led_a <= led_a[4:1];
      lan_led_b <= led_b[4:1];
      wan_led_a_oe <= !in_rst;
      wan_led_b_oe <= !in_rst;
      lan_led_oe <= !in_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  rst_qualify_a: assert property (low_full && !hold_in_rst |=> ##1 in_rst)
    else $error("qualified reset pin did not enter reset");
  pins_float_a: assert property (in_rst |=> !wan_led_a_oe && !wan_led_b_oe && !lan_led_oe)
    else $error("output enabled during reset");
  hold_time_a: assert property (run && !hold_done |=> sys_reset_out == !pol_r)
    else $error("reset output released early");
  out_level_a: assert property (run && hold_done && !wdt_expire |=> sys_reset_out == pol_r)
    else $error("reset output inactive level wrong");
  width_capture_a: assert property (capture |=> bw_r == $past(pin_s_r[5:4]))
    else $error("boot width strap not captured");
  clk_capture_a: assert property (capture |=> ##1 cpu_clk_from_test == $past(pin_s_r[3], 2))
    else $error("clock source strap not captured");
  wan_a_link_a: assert property (wan_sel_a == 3'h1 |=> wan_led_a_drv == $past(link_st[0]))
    else $error("wan led a not showing link");
  wan_b_dup_a: assert property (wan_sel_b == 3'h2 |=> wan_led_b_drv == $past(duplex_st[0]))
    else $error("wan led b not showing duplex");
  lan_a_act_a: assert property (lan_sel_a == 3'h4 |=> lan_led_a == $past(act_st[4:1]))
    else $error("lan led a not showing activity");
  lan_b_col_a: assert property (lan_sel_b == 3'h3 |=> lan_led_b == $past(col_st[4:1]))
    else $error("lan led b not showing collision");
  wdt_reset_a: assert property (run && wdt_expire && !hold_in_rst |=> ##1 core_reset_out)
    else $error("watchdog expiry did not reset core");
  strap_keep_a: assert property (run && $past(run) |-> $stable(bw_r) && $stable(pol_r))
    else $error("strap value moved outside reset");
endmodule : rslc_top

// *** tb/rslc_board.sv ***
// Purpose: board model: reset pulse source, strap resistors, wan led pins
// Assumes: pll lock follows lock_set from the bench, with no delay
// Notes: strap resistors win only while the device floats the led pins
module rslc_board (
  input wire logic mclk,
  input wire logic pulse_req,
  input wire logic [7:0] pulse_len,
  input wire logic pol_set,
  input wire logic clk_set,
  input wire logic [1:0] width_set,
  input wire logic lock_set,
  input wire logic led_a_drv,
  input wire logic led_a_oe,
  input wire logic led_b_drv,
  input wire logic led_b_oe,
  output logic chip_reset_n,
  output logic pll_locked,
  output logic pol_strap,
  output logic clk_strap,
  output logic led_a_pin,
  output logic led_b_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] low_r = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (pulse_req) begin
      low_r <= pulse_len;
    end else if (low_r != 8'h00) begin
      low_r <= low_r - 8'h01;
    end
  end
  assign chip_reset_n = (low_r == 8'h00);
  assign pll_locked = lock_set;
  // no default on the polarity strap, so the board always drives it
  assign pol_strap = pol_set;
  assign clk_strap = clk_set;
  assign led_a_pin = led_a_oe ? led_a_drv : width_set[0];
  assign led_b_pin = led_b_oe ? led_b_drv : width_set[1];
endmodule : rslc_board

// *** tb/testbench.sv ***
// Purpose: self-checking bench for rslc_top
// Assumes: HOLD_CYC cut to 64; board model drives pins and straps
// Notes: readies sampled on falling edges, bus changed on rising edges
`include "rslc_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 64;
  logic mclk, sys_rst, chip_reset_n, pll_locked, req, pol_set, clk_set, lock_set;
  logic reset_out_polarity_strap, cpu_clock_source_strap, wan_led_a_pin, wan_led_b_pin;
  logic [7:0] len;
  logic [1:0] width_set, boot_bank_width, s_axi_bresp, s_axi_rresp;
  logic [4:0] speed_st, link_st, duplex_st, col_st, act_st;
  logic sys_reset_out, core_reset_out, cpu_clk_from_test, lan_led_oe;
  logic wan_led_a_drv, wan_led_a_oe, wan_led_b_drv, wan_led_b_oe;
  logic [3:0] lan_led_a, lan_led_b, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errors, check_count;

  rslc_top #(.HOLD_CYC(HOLD)) DUT (.mclk, .sys_rst, .chip_reset_n, .pll_locked,
    .reset_out_polarity_strap, .cpu_clock_source_strap, .wan_led_a_pin, .wan_led_b_pin,
    .speed_st, .link_st, .duplex_st, .col_st, .act_st, .sys_reset_out, .core_reset_out,
    .cpu_clk_from_test, .boot_bank_width, .wan_led_a_drv, .wan_led_a_oe, .wan_led_b_drv,
    .wan_led_b_oe, .lan_led_a, .lan_led_b, .lan_led_oe, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  rslc_board board (.mclk(mclk), .pulse_req(req), .pulse_len(len), .pol_set(pol_set),
    .clk_set(clk_set), .width_set(width_set), .lock_set(lock_set), .led_a_drv(wan_led_a_drv),
    .led_a_oe(wan_led_a_oe), .led_b_drv(wan_led_b_drv), .led_b_oe(wan_led_b_oe),
    .chip_reset_n(chip_reset_n), .pll_locked(pll_locked),
    .pol_strap(reset_out_polarity_strap), .clk_strap(cpu_clock_source_strap),
    .led_a_pin(wan_led_a_pin), .led_b_pin(wan_led_b_pin));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    logic pa, pw, ta, tw, tk;
    pa = 1'b1;
    pw = 1'b1;
    rsp = 2'h3;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge mclk);
      ta = pa & s_axi_awready;
      tw = pw & s_axi_wready;
      tk = !pa & !pw & s_axi_bvalid;
      if (tk) rsp = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) pa = 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tw) pw = 1'b0;
      if (tk) s_axi_bready <= 1'b0;
      if (tk) break;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    logic pa, pr, ta, tr;
    pa = 1'b1;
    pr = 1'b1;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 100 && (pa || pr); i++) begin
      @(negedge mclk);
      ta = pa & s_axi_arready;
      tr = pr & s_axi_rvalid;
      if (tr) d = s_axi_rdata;
      if (tr) rsp = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (ta) pa = 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      if (tr) pr = 1'b0;
    end
  endtask : axi_rd

  // counts falling edges while the reset output keeps its present level
  task automatic hold_chk(input int minc);
    logic act;
    int n;
    act = sys_reset_out;
    n = 0;
    while (sys_reset_out === act && n < HOLD + 200) begin
      @(negedge mclk);
      n++;
    end
    chk("reset out hold", n >= minc, 1'b1);
  endtask : hold_chk

  function automatic logic [4:0] ledf(input int k);
    case (k)
      0: ledf = speed_st;
      1: ledf = link_st;
      2: ledf = duplex_st;
      3: ledf = col_st;
      4: ledf = act_st;
      5: ledf = duplex_st & col_st;
      6: ledf = link_st & ~act_st;
      default: ledf = 5'h00;
    endcase
  endfunction : ledf

  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] rv [4];
    logic [4:0] ea, eb;
    logic [1:0] r;
    logic flag;
    rv = '{`RSLC_WAN_MISC_RST, `RSLC_SW_CTRL0_RST, 32'h0, `RSLC_WDT_LOAD_RST};
    {sys_rst, req, len, pol_set, clk_set, width_set} = {1'b1, 1'b0, 8'd70, 4'h1};
    lock_set = 1'b1;
    {speed_st, link_st, duplex_st, col_st, act_st} = 25'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      pol_set <= i[0];
      clk_set <= i[0];
      width_set <= i[0] ? 2'h2 : 2'h1;
      req <= 1'b1;
      @(posedge mclk);
      req <= 1'b0;
      repeat (58) @(posedge mclk);
      @(negedge mclk);
      chk("oe in reset", {wan_led_a_oe, wan_led_b_oe, lan_led_oe}, 3'h0);
      chk("reset out level", sys_reset_out, !i[0]);
      hold_chk(HOLD);
      chk("boot width", boot_bank_width, i[0] ? 2'h2 : 2'h1);
      chk("clock source", cpu_clk_from_test, i[0]);
      chk("oe in run", {wan_led_a_oe, wan_led_b_oe, lan_led_oe}, 3'h7);
      pol_set <= !i[0];
      clk_set <= !i[0];
      repeat (5) @(negedge mclk);
      chk("clock source held", cpu_clk_from_test, i[0]);
      chk("reset out idle", sys_reset_out, i[0]);
    end
    for (int i = 0; i < 4; i++) begin
      axi_rd(8'(4 * i), d, r);
      chk("reg reset value", d, rv[i]);
    end
    axi_rd(8'h14, d, r);
    chk("unmapped read resp", {d, r}, {32'h0, `RSLC_RESP_SLVERR});
    axi_wr(8'h14, 32'hFFFF_FFFF, r);
    chk("unmapped write resp", r, `RSLC_RESP_SLVERR);
    for (int k = 0; k < 8; k++) begin
      axi_wr(`RSLC_OFF_WAN_MISC, 32'(k) | (32'(7 - k) << `RSLC_WAN_B_LSB), r);
      axi_wr(`RSLC_OFF_SW_CTRL0, (32'(k) << `RSLC_LAN_A_LSB) | (32'(7 - k) << `RSLC_LAN_B_LSB), r);
      for (int n = 0; n < 2; n++) begin
        @(posedge mclk);
        speed_st <= 5'h15 ^ {5{n[0]}};
        link_st <= 5'h19 ^ {5{n[0]}};
        duplex_st <= 5'h0E ^ {5{n[0]}};
        col_st <= 5'h07 ^ {5{n[0]}};
        act_st <= 5'h12 ^ {5{n[0]}};
        repeat (3) @(negedge mclk);
        ea = ledf(k);
        eb = ledf(7 - k);
        chk("wan led a", wan_led_a_drv, ea[0]);
        chk("wan led b", wan_led_b_drv, eb[0]);
        chk("lan led a", lan_led_a, ea[4:1]);
        chk("lan led b", lan_led_b, eb[4:1]);
      end
    end
    axi_wr(`RSLC_OFF_WDT_LOAD, 32'd100, r);
    axi_wr(`RSLC_OFF_WDT_CTRL, 32'h1, r);
    for (int n = 0; n < 300 && core_reset_out !== 1'b1; n++) @(negedge mclk);
    chk("watchdog core reset", core_reset_out, 1'b1);
    chk("watchdog reset out", sys_reset_out, 1'b0);
    hold_chk(HOLD - 4);
    axi_rd(`RSLC_OFF_STATUS, d, r);
    chk("watchdog flag", d & 32'h30, 32'h20);
    axi_rd(`RSLC_OFF_WAN_MISC, d, r);
    chk("regs to default", d, `RSLC_WAN_MISC_RST);
    len <= 8'd20;
    req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    flag = 1'b0;
    repeat (80) begin
      @(negedge mclk);
      flag = flag | core_reset_out;
    end
    chk("short pulse ignored", flag, 1'b0);
    lock_set <= 1'b0;
    repeat (10) @(negedge mclk);
    chk("unlocked pll holds reset", core_reset_out, 1'b1);
    @(posedge mclk);
    lock_set <= 1'b1;
    repeat (10) @(negedge mclk);
    chk("locked pll releases reset", core_reset_out, 1'b0);
    final_report();
  end
endmodule : testbench
